//--- core/aphc_defs.svh
`ifndef APHC_DEFS_SVH
`define APHC_DEFS_SVH

// control byte field positions
`define APHC_PD_HI 7
`define APHC_PD_LO 6
`define APHC_ACQ_SEL 5
`define APHC_SGL_SEL 4
`define APHC_UNI_SEL 3
`define APHC_CH_HI 2
`define APHC_CH_LO 0

// reset values: external clock, everything else cleared
`define APHC_CTRL_RESET 8'hC0
`define APHC_CLK_EXT_RESET 1'b1

// timing
`define APHC_MCLK_NS 50
`define APHC_RESET_NS 10000
`define APHC_RESET_CYC ((`APHC_RESET_NS + `APHC_MCLK_NS - 1) / `APHC_MCLK_NS)
`define APHC_ACQ_TICKS 3
`define APHC_CONV_TICKS 13
`define APHC_INT_DIV 5

`define APHC_RES_W 12

`endif

//--- core/aphc_pkg.sv
package aphc_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ = 2'b01,
        ST_CONV = 2'b11
    } aphc_state_type;

    typedef enum logic [1:0] {
        PWR_ON = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_SHUTDOWN = 2'b11
    } aphc_power_type;

endpackage : aphc_pkg

//--- core/aphc_sar.sv
`timescale 1ns/1ps
`include "aphc_defs.svh"

module aphc_sar #(
    parameter int RES_W = `APHC_RES_W,
    parameter int CONV_TICKS = `APHC_CONV_TICKS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic comp_hi,
    output logic [RES_W-1:0] dac_code,
    output logic busy,
    output logic done,
    output logic [RES_W-1:0] result
);

    generate
        if (CONV_TICKS != RES_W + 1 || RES_W < 2 || RES_W > 15) begin : g_chk
            $error("aphc_sar: conversion must be one tick longer than the resolution");
        end
    endgenerate

    logic [3:0] step_q;
    logic busy_q;
    logic done_q;
    logic [RES_W-1:0] code_q;
    logic [RES_W-1:0] result_q;

    // one decision per tick, msb first; last tick only publishes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            step_q <= 4'h0;
            busy_q <= 1'b0;
            code_q <= {1'b1, {(RES_W-1){1'b0}}};
        end else if (start) begin
            step_q <= 4'h0;
            busy_q <= 1'b1;
            code_q <= {1'b1, {(RES_W-1){1'b0}}};
        end else if (abort) begin
            // idle at midscale: the synchronised comparator has settled before a start
            busy_q <= 1'b0;
            code_q <= {1'b1, {(RES_W-1){1'b0}}};
        end else if (busy_q && tick) begin
            step_q <= step_q + 4'h1;
            if (step_q == 4'(RES_W)) begin
                busy_q <= 1'b0;
                code_q <= {1'b1, {(RES_W-1){1'b0}}};
            end else begin
                // keep the trial bit only when the input is above the dac level
                code_q[RES_W-1-step_q] <= comp_hi;
                if (step_q < 4'(RES_W - 1)) begin
                    code_q[RES_W-2-step_q] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
            result_q <= '0;
        end else begin
            done_q <= busy_q && tick && !start && !abort && step_q == 4'(RES_W);
            if (busy_q && tick && step_q == 4'(RES_W)) begin
                result_q <= code_q;
            end
        end
    end

    assign dac_code = code_q;
    assign busy = busy_q;
    assign done = done_q;
    assign result = result_q;

endmodule : aphc_sar

//--- core/aphc_control.sv
`timescale 1ns/1ps
`include "aphc_defs.svh"

module aphc_control
    import aphc_pkg::*;
#(
    parameter int INT_DIV = `APHC_INT_DIV,
    parameter int ACQ_TICKS = `APHC_ACQ_TICKS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic conv_clk_pin,
    input wire logic [7:0] data_pins_in,
    output logic [`APHC_RES_W-1:0] data_pins_out,
    output logic data_pins_oe,
    output logic conv_done_n,
    input wire logic comp_hi,
    output logic [`APHC_RES_W-1:0] dac_code,
    output logic track,
    output logic [2:0] channel_sel,
    output logic single_ended_select,
    output logic unipolar_select,
    output logic standby,
    output logic shutdown,
    output logic int_osc_en
);

    localparam int RESET_CYC = `APHC_RESET_CYC;

    generate
        if (INT_DIV < 4 || ACQ_TICKS < 1 || ACQ_TICKS > 15) begin : g_chk
            $error("aphc_control: divider must leave room for input synchronisers");
        end
    endgenerate

    // every pin passes two flops; data rides with the strobes so they stay aligned
    logic [12:0] pin_s1_q;
    logic [12:0] pin_s2_q;
    logic [2:0] edge_p_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= 13'h0007;
            pin_s2_q <= 13'h0007;
            edge_p_q <= 3'h7;
        end else begin
            pin_s1_q <= {comp_hi, data_pins_in, conv_clk_pin, rd_n, wr_n, cs_n};
            pin_s2_q <= pin_s1_q;
            edge_p_q <= {pin_s2_q[3], pin_s2_q[2], pin_s2_q[1]};
        end
    end

    logic cs_low;
    logic wr_rise;
    logic rd_fall;
    logic ext_tick;
    logic [7:0] din;
    logic comp_s;
    assign cs_low = !pin_s2_q[0];
    assign wr_rise = cs_low && pin_s2_q[1] && !edge_p_q[0];
    assign rd_fall = cs_low && !pin_s2_q[2] && edge_p_q[1];
    assign ext_tick = cs_low && pin_s2_q[3] && !edge_p_q[2];
    assign din = pin_s2_q[11:4];
    assign comp_s = pin_s2_q[12];

    // reset phase: writes are refused until it has run out
    logic [7:0] rst_cnt_q;
    logic ready_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rst_cnt_q <= 8'h00;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            rst_cnt_q <= rst_cnt_q + 8'h01;
            ready_q <= rst_cnt_q == 8'(RESET_CYC - 1);
        end
    end

    logic wr_take;
    assign wr_take = wr_rise && ready_q;

    logic [7:0] ctrl_q;
    logic clk_ext_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `APHC_CTRL_RESET;
            clk_ext_q <= `APHC_CLK_EXT_RESET;
        end else if (wr_take) begin
            ctrl_q <= din;
            // clock source only follows the two running codes
            if (din[`APHC_PD_HI]) begin
                clk_ext_q <= din[`APHC_PD_LO];
            end
        end
    end

    aphc_power_type power_q;
    logic sar_done;
    logic sar_busy;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            power_q <= PWR_ON;
        end else if (wr_take) begin
            power_q <= PWR_ON;
        end else if (sar_done && !ctrl_q[`APHC_PD_HI]) begin
            // the requesting write's own conversion finishes first
            power_q <= ctrl_q[`APHC_PD_LO] ? PWR_STANDBY : PWR_SHUTDOWN;
        end
    end

    // internal oscillator stand-in: divided mclk, only while running
    logic [7:0] div_q;
    logic int_tick;
    assign int_osc_en = !clk_ext_q && power_q == PWR_ON;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_q <= 8'h00;
        end else if (!int_osc_en || div_q == 8'(INT_DIV - 1)) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign int_tick = int_osc_en && div_q == 8'(INT_DIV - 1);

    logic tick;
    assign tick = clk_ext_q ? ext_tick : int_tick;

    aphc_state_type state_q;
    logic acq_ext_q;
    logic [3:0] acq_cnt_q;
    logic ext_conv_go;
    logic int_conv_go;
    logic sar_start;
    logic sar_abort;
    assign ext_conv_go = wr_take && state_q == ST_ACQ && acq_ext_q && !din[`APHC_ACQ_SEL];
    assign int_conv_go = !wr_take && state_q == ST_ACQ && !acq_ext_q && tick
        && acq_cnt_q == 4'(ACQ_TICKS - 1);
    assign sar_start = ext_conv_go || int_conv_go;
    assign sar_abort = wr_take && !sar_start;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            acq_ext_q <= 1'b0;
            acq_cnt_q <= 4'h0;
        end else if (sar_start) begin
            state_q <= ST_CONV;
        end else if (wr_take) begin
            state_q <= ST_ACQ;
            acq_ext_q <= din[`APHC_ACQ_SEL];
            acq_cnt_q <= 4'h0;
        end else if (state_q == ST_ACQ && tick) begin
            acq_cnt_q <= acq_cnt_q + 4'h1;
        end else if (state_q == ST_CONV && sar_done) begin
            state_q <= ST_IDLE;
        end
    end

    logic [`APHC_RES_W-1:0] sar_result;
    aphc_sar aphc_sar_inst (
        .mclk(mclk),
        .rst(rst),
        .tick(tick),
        .start(sar_start),
        .abort(sar_abort),
        .comp_hi(comp_s),
        .dac_code(dac_code),
        .busy(sar_busy),
        .done(sar_done),
        .result(sar_result)
    );

    // result only moves at the end of a conversion, so a late read still sees it
    logic [`APHC_RES_W-1:0] result_q;
    logic done_n_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            result_q <= '0;
        end else if (sar_done) begin
            if (ctrl_q[`APHC_UNI_SEL]) begin
                result_q <= sar_result;
            end else begin
                // offset binary to two's complement: flip the sign bit
                result_q <= {~sar_result[`APHC_RES_W-1], sar_result[`APHC_RES_W-2:0]};
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            done_n_q <= 1'b1;
        end else if (sar_done) begin
            done_n_q <= 1'b0;
        end else if (rd_fall || wr_take) begin
            done_n_q <= 1'b1;
        end
    end

    assign data_pins_out = result_q;
    assign data_pins_oe = cs_low && !pin_s2_q[2];
    assign conv_done_n = done_n_q;
    assign track = state_q == ST_ACQ;
    assign channel_sel = ctrl_q[`APHC_CH_HI:`APHC_CH_LO];
    assign single_ended_select = ctrl_q[`APHC_SGL_SEL];
    assign unipolar_select = ctrl_q[`APHC_UNI_SEL];
    assign standby = power_q == PWR_STANDBY;
    assign shutdown = power_q == PWR_SHUTDOWN;

    // checks
    a_bus_quiet_cs: assert property (@(posedge mclk) disable iff (rst)
        !cs_low |-> !data_pins_oe) else $error("bus driven with chip select high");
    a_bus_read_only: assert property (@(posedge mclk) disable iff (rst)
        data_pins_oe |-> !pin_s2_q[2] && $stable(result_q) || $past(sar_done))
        else $error("bus driven outside a read");
    a_ctrl_capture: assert property (@(posedge mclk) disable iff (rst)
        wr_take |=> ctrl_q == $past(din)) else $error("control byte not captured");
    a_ext_clk_sel: assert property (@(posedge mclk) disable iff (rst)
        wr_take && din[7:6] == 2'b11 |=> clk_ext_q) else $error("external clock not selected");
    a_int_clk_sel: assert property (@(posedge mclk) disable iff (rst)
        wr_take && din[7:6] == 2'b10 |=> !clk_ext_q && int_osc_en)
        else $error("internal clock not selected");
    a_clk_kept_down: assert property (@(posedge mclk) disable iff (rst)
        wr_take && !din[7] |=> $stable(clk_ext_q)) else $error("clock mode changed by power-down");
    a_done_clear_rd: assert property (@(posedge mclk) disable iff (rst)
        rd_fall && !sar_done |=> conv_done_n) else $error("done flag not cleared by read");
    a_done_on_result: assert property (@(posedge mclk) disable iff (rst)
        sar_done |=> !conv_done_n && result_q == ($past(ctrl_q[3]) ? $past(sar_result)
            : {~$past(sar_result[11]), $past(sar_result[10:0])}))
        else $error("result or done flag wrong after conversion");
    a_no_conv_down: assert property (@(posedge mclk) disable iff (rst)
        power_q != PWR_ON |-> !sar_busy && state_q == ST_IDLE)
        else $error("conversion while powered down");
    a_reset_phase: assert property (@(posedge mclk) disable iff (rst)
        !ready_q |-> state_q == ST_IDLE && ctrl_q == 8'hC0) else $error("activity in reset phase");
    a_wake_write: assert property (@(posedge mclk) disable iff (rst)
        wr_take && power_q != PWR_ON |=> power_q == PWR_ON ##0 state_q != ST_IDLE)
        else $error("write did not wake the converter");
    a_int_acq_len: assert property (@(posedge mclk) disable iff (rst)
        int_conv_go |-> acq_cnt_q == 4'd2 ##1 state_q == ST_CONV)
        else $error("internal acquisition length wrong");
    a_abort_write: assert property (@(posedge mclk) disable iff (rst)
        wr_take && state_q == ST_CONV |=> state_q != ST_CONV || $past(sar_start))
        else $error("conversion not aborted by write");

    c_read_result: cover property (@(posedge mclk) disable iff (rst)
        !conv_done_n ##[1:50] rd_fall);
    c_shutdown: cover property (@(posedge mclk) disable iff (rst) $rose(shutdown));
    c_standby_wake: cover property (@(posedge mclk) disable iff (rst)
        standby ##[1:200] power_q == PWR_ON);
    c_ext_acq_conv: cover property (@(posedge mclk) disable iff (rst) ext_conv_go);

endmodule : aphc_control

//--- dv/aphc_host_model.sv
`timescale 1ns/1ps

module aphc_host_model (
    input wire logic mclk,
    input wire logic data_pins_oe,
    input wire logic [11:0] data_pins_out,
    output logic cs_n,
    output logic wr_n,
    output logic rd_n,
    output logic [7:0] host_bus
);
    int pulse = 3;

    initial begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        host_bus = 8'h5A;
    end

    // select is held across conversions: external ticks count only while selected
    task automatic select(input logic on);
        @(posedge mclk);
        cs_n <= ~on;
    endtask : select

    task automatic write_byte(input logic [7:0] b);
        @(posedge mclk);
        host_bus <= b;
        wr_n <= 1'b0;
        repeat (pulse) @(posedge mclk);
        wr_n <= 1'b1;
        @(posedge mclk);
        host_bus <= ~b; // released bus must not show the stale byte
        repeat (pulse + 2) @(posedge mclk);
    endtask : write_byte

    task automatic read_word(output logic [11:0] w, output logic ok);
        int n;
        n = 0;
        @(posedge mclk);
        rd_n <= 1'b0;
        @(posedge mclk);
        while (data_pins_oe !== 1'b1 && n < 12) begin
            @(posedge mclk);
            n++;
        end
        w = data_pins_out;
        ok = data_pins_oe;
        rd_n <= 1'b1;
        repeat (pulse + 2) @(posedge mclk);
    endtask : read_word
endmodule : aphc_host_model

//--- dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end

module tb_top;
    logic mclk;
    logic rst;
    logic conv_clk_pin;
    logic cs_n, wr_n, rd_n, comp_hi, data_pins_oe, conv_done_n, track;
    logic single_ended_select, unipolar_select, standby, shutdown, int_osc_en, ok;
    logic [7:0] host_bus, data_pins_in;
    logic [11:0] data_pins_out, dac_code, vin, w;
    logic [11:0] vals [3] = '{12'h000, 12'hFFF, 12'hA5C};
    logic [2:0] channel_sel;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // 2.5 MHz, 50% duty, phase unrelated to mclk
    initial begin
        conv_clk_pin = 1'b0;
        #113;
        forever #200 conv_clk_pin = ~conv_clk_pin;
    end

    initial vin = 12'h000;
    // input sits half a step above its code, so the decision never ties
    assign comp_hi = {vin, 1'b1} > {dac_code, 1'b0};
    assign data_pins_in = data_pins_oe ? data_pins_out[7:0] : host_bus;

    aphc_host_model aphc_host_model_inst (.mclk(mclk), .data_pins_oe(data_pins_oe),
        .data_pins_out(data_pins_out), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .host_bus(host_bus));

    aphc_control aphc_control_inst (.mclk(mclk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .conv_clk_pin(conv_clk_pin), .data_pins_in(data_pins_in),
        .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
        .conv_done_n(conv_done_n), .comp_hi(comp_hi), .dac_code(dac_code), .track(track),
        .channel_sel(channel_sel), .single_ended_select(single_ended_select),
        .unipolar_select(unipolar_select), .standby(standby), .shutdown(shutdown),
        .int_osc_en(int_osc_en));

    task automatic report_and_stop();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic wait_done();
        int n;
        n = 0;
        while (conv_done_n !== 1'b0 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        `CHK("conv_done_n low", 1'b0, conv_done_n)
    endtask : wait_done

    task automatic read_chk(input logic [11:0] ex);
        aphc_host_model_inst.read_word(w, ok);
        `CHK("result", ex, w)
        `CHK("conv_done_n high", 1'b1, conv_done_n)
    endtask : read_chk

    task automatic convert(input logic [7:0] b, input logic [11:0] v, input logic [11:0] ex);
        vin <= v;
        aphc_host_model_inst.write_byte(b);
        wait_done();
        read_chk(ex);
    endtask : convert

    initial begin
        rst = 1'b1;
        repeat (19) @(posedge mclk);
        `CHK("conv_done_n rst", 1'b1, conv_done_n)
        `CHK("int_osc_en rst", 1'b0, int_osc_en)
        `CHK("oe rst", 1'b0, data_pins_oe)
        @(posedge mclk);
        rst <= 1'b0;
        aphc_host_model_inst.select(1'b1);
        aphc_host_model_inst.write_byte(8'hFD);
        `CHK("channel early", 3'h0, channel_sel)
        repeat (200) @(posedge mclk);
        // 500 us for the internal reference before any result counts
        repeat (10000) @(posedge mclk);
        aphc_host_model_inst.write_byte(8'hFD);
        `CHK("channel", 3'h5, channel_sel)
        `CHK("single", 1'b1, single_ended_select)
        `CHK("unipolar", 1'b1, unipolar_select)
        `CHK("track ext acq", 1'b1, track)
        `CHK("ext clock", 1'b0, int_osc_en)
        aphc_host_model_inst.write_byte(8'hE2);
        `CHK("channel 2", 3'h2, channel_sel)
        `CHK("single 0", 1'b0, single_ended_select)
        `CHK("unipolar 0", 1'b0, unipolar_select)
        aphc_host_model_inst.write_byte(8'hE8);
        for (int i = 0; i < 3; i++) convert(8'hC8, vals[i], vals[i]);
        convert(8'h80, 12'h123, 12'h923);
        `CHK("int clock", 1'b1, int_osc_en)
        // result of the first conversion read after the next write
        vin <= 12'h3C4;
        aphc_host_model_inst.write_byte(8'h88);
        wait_done();
        vin <= 12'h777;
        aphc_host_model_inst.write_byte(8'h88);
        read_chk(12'h3C4);
        wait_done();
        read_chk(12'h777);
        vin <= 12'h456;
        aphc_host_model_inst.write_byte(8'h88);
        repeat (40) @(posedge mclk);
        vin <= 12'h6AB;
        aphc_host_model_inst.write_byte(8'h88);
        `CHK("track restart", 1'b1, track)
        wait_done();
        read_chk(12'h6AB);
        convert(8'h48, 12'h111, 12'h111);
        repeat (20) @(posedge mclk);
        `CHK("standby", 1'b1, standby)
        `CHK("osc off", 1'b0, int_osc_en)
        `CHK("no conv", 1'b1, conv_done_n)
        vin <= 12'h222;
        aphc_host_model_inst.write_byte(8'h48);
        `CHK("standby wake", 1'b0, standby)
        `CHK("clock kept", 1'b1, int_osc_en)
        wait_done();
        read_chk(12'h222);
        vin <= 12'h5E1;
        aphc_host_model_inst.write_byte(8'h08);
        repeat (20) @(posedge mclk);
        `CHK("shutdown wait", 1'b0, shutdown)
        wait_done();
        repeat (4) @(posedge mclk);
        `CHK("shutdown", 1'b1, shutdown)
        read_chk(12'h5E1);
        convert(8'hC8, 12'h9E7, 12'h9E7);
        `CHK("shutdown exit", 1'b0, shutdown)
        aphc_host_model_inst.select(1'b0);
        aphc_host_model_inst.write_byte(8'hF5);
        `CHK("channel ignored", 3'h0, channel_sel)
        `CHK("track ignored", 1'b0, track)
        aphc_host_model_inst.read_word(w, ok);
        `CHK("oe deselected", 1'b0, ok)
        report_and_stop();
    end
endmodule : tb_top
